// ==== adcsc_analog_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcsc_analog_model (
  input wire logic clk,
  input wire logic [2:0] mux_sel,
  input wire logic sample_hold,
  input wire logic [9:0] dac_code,
  output logic comp_hi
);
  // channel n holds level {n, 2a}, frozen outside the sample phase
  logic [9:0] held_q = 10'h000;
  always @(posedge clk) begin
    if (sample_hold) begin
      held_q <= {mux_sel, 7'h2a};
    end
  end
  assign comp_hi = (held_q >= dac_code);
endmodule
`default_nettype wire

// ==== adcsc_clkdiv.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcsc_clkdiv (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] div,
  output logic tick
);
  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } adcsc_div_s;

  adcsc_div_s s_q;
  adcsc_div_s s_d;

  // one tick every div+1 module clocks
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= div) begin
      s_d.cnt = 6'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule
`default_nettype wire

// ==== adcsc_pkg.sv ====
package adcsc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GCTL = 8'h04;
  localparam logic [7:0] OFF_SEQFB = 8'h08;
  localparam logic [7:0] OFF_SEQLO = 8'h0C;
  localparam logic [7:0] OFF_SEQHI = 8'h10;
  localparam logic [7:0] OFF_PRIO = 8'h14;
  localparam logic [7:0] OFF_EXC = 8'h18;
  localparam logic [7:0] OFF_GSTAT = 8'h74;
  // conversion_control_status fields
  localparam int CTRL_PWR_BIT = 0;
  localparam int CTRL_SOC_BIT = 2;
  localparam int CTRL_EOC_BIT = 3;
  localparam int CTRL_MUX_LSB = 4;
  // global_control fields
  localparam int GCTL_DIV_LSB = 0;
  localparam int GCTL_PWR_LSB = 8;
  // global_status fields
  localparam int GSTAT_BUSY_BIT = 0;
  localparam int GSTAT_SAMPLE_BIT = 1;
  localparam int GSTAT_ACTIVE_CHANNEL_NUMBER_LSB = 3;
  localparam int GSTAT_PWR_LSB = 8;
  // sequencer_feedback_reg fields
  localparam int SEQFB_RUN_BIT = 0;
  localparam int SEQFB_SW_BIT = 8;
  localparam int SEQFB_SUSP_BIT = 9;
  localparam int SEQFB_ESM_BIT = 10;
  localparam int SEQFB_EIM_BIT = 11;
  // priority measurement config fields
  localparam int PRIO_CH_LSB = 0;
  localparam int PRIO_REP_LSB = 8;
  // analog power level encoding
  localparam logic [1:0] PWR_NORMAL = 2'h3;
  // converter timing in base converter clock ticks
  localparam logic [2:0] SAMPLE_TICKS = 3'h4;
  localparam logic [2:0] BIT_TICKS = 3'h4;
  localparam logic [9:0] SAR_MSB = 10'h200;
  localparam logic [3:0] SAR_TOP = 4'h9;
  localparam int RES_W = 10;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcsc_state_e;
  typedef enum logic [1:0] {SRC_SEQ, SRC_EIM, SRC_ESM, SRC_SW} adcsc_src_e;
endpackage

// ==== adcsc_top.sv ====
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adcsc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic converter_debug_suspend,
  input wire logic priority_event,
  input wire logic exception_event,
  input wire logic comp_hi,
  output logic [2:0] mux_sel,
  output logic sample_hold,
  output logic [9:0] dac_code,
  output logic power_up_bit,
  output logic [1:0] analog_power_level,
  output logic [79:0] ch_result,
  output logic [7:0] ch_valid,
  output logic dma_req,
  output logic irq_conv,
  output logic irq_eim,
  output logic irq_esm
);
  typedef struct packed {
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pwr_up;
    logic [2:0] mux_sw;
    logic eoc;
    logic [1:0] plevel;
    logic [1:0] pstate;
    logic [5:0] div;
    logic run;
    logic sw_mode;
    logic [31:0] seq_lo;
    logic [31:0] seq_hi;
    logic [2:0] prio_ch;
    logic [6:0] prio_rep;
    logic [7:0] exc_mask;
    adcsc_pkg::adcsc_state_e st;
    adcsc_pkg::adcsc_src_e src;
    logic [2:0] chan;
    logic [5:0] pos;
    logic [7:0] eim_left;
    logic [7:0] esm_left;
    logic [2:0] tick_cnt;
    logic [3:0] bit_idx;
    logic [9:0] sar;
    logic [2:0] active_channel_number;
    logic cmp_m;
    logic cmp_s;
    logic [79:0] res;
    logic [7:0] res_valid;
    logic dma_req;
    logic irq_conv;
    logic irq_eim;
    logic irq_esm;
  } adcsc_state_s;

  adcsc_state_s s_q;
  adcsc_state_s s_d;
  logic tick;
  logic wr_go;
  logic rd_go;
  logic [63:0] seq_mask;
  logic any_en;
  logic seq_found;
  logic [5:0] seq_idx;
  logic [2:0] esm_ch;
  logic ev_ok;
  logic eim_take;
  logic esm_take;
  logic soc_req;
  logic conv_start;
  logic conv_done;

  adcsc_clkdiv u_div (
    .clk(clk),
    .rst(rst),
    .div(s_q.div),
    .tick(tick)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign seq_mask = {s_q.seq_hi, s_q.seq_lo};
  assign any_en = |seq_mask;

  // next enabled channel at or after the sequence pointer, wrapping
  always_comb begin
    seq_found = 1'b0;
    seq_idx = 6'h00;
    for (int i = 0; i < 64; i++) begin
      if (!seq_found && seq_mask[6'(s_q.pos + 6'(i))]) begin
        seq_found = 1'b1;
        seq_idx = 6'(s_q.pos + 6'(i));
      end
    end
  end

  always_comb begin
    esm_ch = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (s_q.esm_left[i]) begin
        esm_ch = 3'(i);
      end
    end
  end

  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_go = s_axi_awready;
  assign s_axi_arready = !s_q.rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign soc_req = wr_go && s_axi_awaddr == adcsc_pkg::OFF_CTRL && s_axi_wstrb[0]
    && s_axi_wdata[adcsc_pkg::CTRL_SOC_BIT];
  assign ev_ok = s_q.run && !s_q.sw_mode && any_en && !converter_debug_suspend;
  assign eim_take = priority_event && ev_ok;
  assign esm_take = exception_event && ev_ok && s_q.esm_left == 8'h00;
  assign conv_start = s_q.st == adcsc_pkg::ST_IDLE && s_d.st == adcsc_pkg::ST_SAMPLE;
  // only a finished conversion posts a result; an abort from convert does not
  assign conv_done = s_d.res_valid != 8'h00;

  always_comb begin
    logic go;
    logic [2:0] go_ch;
    logic [9:0] nsar;
    adcsc_pkg::adcsc_src_e go_src;
    go = 1'b0;
    go_ch = 3'h0;
    nsar = s_q.sar;
    go_src = adcsc_pkg::SRC_SW;
    s_d = s_q;
    s_d.res_valid = 8'h00;
    s_d.dma_req = 1'b0;
    s_d.irq_conv = 1'b0;
    s_d.irq_eim = 1'b0;
    s_d.irq_esm = 1'b0;
    s_d.cmp_m = comp_hi;
    s_d.cmp_s = s_q.cmp_m;
    s_d.pstate = s_q.plevel;
    // bus write
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = adcsc_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        adcsc_pkg::OFF_CTRL: begin
          if (s_axi_wstrb[0]) begin
            s_d.pwr_up = s_axi_wdata[adcsc_pkg::CTRL_PWR_BIT];
            s_d.mux_sw = s_axi_wdata[adcsc_pkg::CTRL_MUX_LSB +: 3];
          end
        end
        adcsc_pkg::OFF_GCTL: begin
          if (s_axi_wstrb[0]) begin
            s_d.div = s_axi_wdata[adcsc_pkg::GCTL_DIV_LSB +: 6];
          end
          if (s_axi_wstrb[1]) begin
            s_d.plevel = s_axi_wdata[adcsc_pkg::GCTL_PWR_LSB +: 2];
          end
        end
        adcsc_pkg::OFF_SEQFB: begin
          if (s_axi_wstrb[0]) begin
            s_d.run = s_axi_wdata[adcsc_pkg::SEQFB_RUN_BIT];
          end
        end
        adcsc_pkg::OFF_SEQLO: s_d.seq_lo = merge(s_q.seq_lo, s_axi_wdata, s_axi_wstrb);
        adcsc_pkg::OFF_SEQHI: s_d.seq_hi = merge(s_q.seq_hi, s_axi_wdata, s_axi_wstrb);
        adcsc_pkg::OFF_PRIO: begin
          if (s_axi_wstrb[0]) begin
            s_d.prio_ch = s_axi_wdata[adcsc_pkg::PRIO_CH_LSB +: 3];
          end
          if (s_axi_wstrb[1]) begin
            s_d.prio_rep = s_axi_wdata[adcsc_pkg::PRIO_REP_LSB +: 7];
          end
        end
        adcsc_pkg::OFF_EXC: begin
          if (s_axi_wstrb[0]) begin
            s_d.exc_mask = s_axi_wdata[7:0];
          end
        end
        adcsc_pkg::OFF_GSTAT: s_d.bresp = adcsc_pkg::RESP_OKAY;
        default: s_d.bresp = adcsc_pkg::RESP_SLVERR;
      endcase
    end
    // bus read
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = adcsc_pkg::RESP_OKAY;
      s_d.rdata = adcsc_pkg::RESET_WORD;
      case (s_axi_araddr)
        adcsc_pkg::OFF_CTRL: begin
          s_d.rdata[adcsc_pkg::CTRL_PWR_BIT] = s_q.pwr_up;
          s_d.rdata[adcsc_pkg::CTRL_SOC_BIT] = s_q.st != adcsc_pkg::ST_IDLE
            && s_q.src == adcsc_pkg::SRC_SW;
          s_d.rdata[adcsc_pkg::CTRL_EOC_BIT] = s_q.eoc;
          s_d.rdata[adcsc_pkg::CTRL_MUX_LSB +: 3] = s_q.mux_sw;
          s_d.eoc = 1'b0;
        end
        adcsc_pkg::OFF_GCTL: begin
          s_d.rdata[adcsc_pkg::GCTL_DIV_LSB +: 6] = s_q.div;
          s_d.rdata[adcsc_pkg::GCTL_PWR_LSB +: 2] = s_q.plevel;
        end
        adcsc_pkg::OFF_SEQFB: begin
          s_d.rdata[adcsc_pkg::SEQFB_RUN_BIT] = s_q.run;
          s_d.rdata[adcsc_pkg::SEQFB_SW_BIT] = s_q.sw_mode;
          s_d.rdata[adcsc_pkg::SEQFB_SUSP_BIT] = s_q.run && !s_q.sw_mode && !any_en;
          s_d.rdata[adcsc_pkg::SEQFB_ESM_BIT] = s_q.esm_left != 8'h00;
          s_d.rdata[adcsc_pkg::SEQFB_EIM_BIT] = s_q.eim_left != 8'h00;
        end
        adcsc_pkg::OFF_SEQLO: s_d.rdata = s_q.seq_lo;
        adcsc_pkg::OFF_SEQHI: s_d.rdata = s_q.seq_hi;
        adcsc_pkg::OFF_PRIO: begin
          s_d.rdata[adcsc_pkg::PRIO_CH_LSB +: 3] = s_q.prio_ch;
          s_d.rdata[adcsc_pkg::PRIO_REP_LSB +: 7] = s_q.prio_rep;
        end
        adcsc_pkg::OFF_EXC: s_d.rdata[7:0] = s_q.exc_mask;
        adcsc_pkg::OFF_GSTAT: begin
          s_d.rdata[adcsc_pkg::GSTAT_BUSY_BIT] = s_q.st != adcsc_pkg::ST_IDLE;
          s_d.rdata[adcsc_pkg::GSTAT_SAMPLE_BIT] = s_q.st == adcsc_pkg::ST_SAMPLE;
          s_d.rdata[adcsc_pkg::GSTAT_ACTIVE_CHANNEL_NUMBER_LSB +: 3] = s_q.active_channel_number;
          s_d.rdata[adcsc_pkg::GSTAT_PWR_LSB +: 2] = s_q.pstate;
        end
        default: s_d.rresp = adcsc_pkg::RESP_SLVERR;
      endcase
    end
    // inserted events
    if (eim_take) begin
      s_d.eim_left = {1'b0, s_q.prio_rep} + 8'h01;
    end
    if (esm_take) begin
      s_d.esm_left = s_q.exc_mask;
    end
    if (s_q.st != adcsc_pkg::ST_IDLE && ((eim_take && (s_q.src == adcsc_pkg::SRC_SEQ
        || s_q.src == adcsc_pkg::SRC_ESM)) || (esm_take && s_q.src == adcsc_pkg::SRC_SEQ))) begin
      s_d.st = adcsc_pkg::ST_IDLE;
    end else begin
      case (s_q.st)
        adcsc_pkg::ST_IDLE: begin
          if (!s_q.run && !s_q.sw_mode) begin
            s_d.sw_mode = 1'b1;
            s_d.eim_left = 8'h00;
            s_d.esm_left = 8'h00;
          end else if (s_q.run && s_q.sw_mode) begin
            s_d.sw_mode = 1'b0;
            s_d.pos = 6'h00;
          end else if (s_q.pwr_up && s_q.plevel == adcsc_pkg::PWR_NORMAL) begin
            if (!s_q.sw_mode && !converter_debug_suspend) begin
              if (s_q.eim_left != 8'h00) begin
                go = 1'b1;
                go_src = adcsc_pkg::SRC_EIM;
                go_ch = s_q.prio_ch;
              end else if (s_q.esm_left != 8'h00) begin
                go = 1'b1;
                go_src = adcsc_pkg::SRC_ESM;
                go_ch = esm_ch;
              end else if (seq_found) begin
                go = 1'b1;
                go_src = adcsc_pkg::SRC_SEQ;
                go_ch = seq_idx[2:0];
                s_d.pos = seq_idx;
              end
            end else if (s_q.sw_mode && soc_req) begin
              go = 1'b1;
              go_src = adcsc_pkg::SRC_SW;
              // channel from the same write that carries the start bit
              go_ch = s_axi_wdata[adcsc_pkg::CTRL_MUX_LSB +: 3];
            end
          end
          if (go) begin
            s_d.st = adcsc_pkg::ST_SAMPLE;
            s_d.src = go_src;
            s_d.chan = go_ch;
            s_d.active_channel_number = go_ch;
            s_d.tick_cnt = 3'h0;
          end
        end
        adcsc_pkg::ST_SAMPLE: begin
          if (tick) begin
            if (s_q.tick_cnt == adcsc_pkg::SAMPLE_TICKS - 3'h1) begin
              s_d.st = adcsc_pkg::ST_CONVERT;
              s_d.sar = adcsc_pkg::SAR_MSB;
              s_d.bit_idx = adcsc_pkg::SAR_TOP;
              s_d.tick_cnt = 3'h0;
            end else begin
              s_d.tick_cnt = s_q.tick_cnt + 3'h1;
            end
          end
        end
        adcsc_pkg::ST_CONVERT: begin
          if (tick) begin
            if (s_q.tick_cnt == adcsc_pkg::BIT_TICKS - 3'h1) begin
              s_d.tick_cnt = 3'h0;
              if (!s_q.cmp_s) begin
                nsar[s_q.bit_idx] = 1'b0;
              end
              if (s_q.bit_idx == 4'h0) begin
                s_d.st = adcsc_pkg::ST_IDLE;
                s_d.res[s_q.chan*adcsc_pkg::RES_W +: adcsc_pkg::RES_W] = nsar;
                s_d.res_valid[s_q.chan] = 1'b1;
                s_d.dma_req = 1'b1;
                s_d.irq_conv = 1'b1;
                s_d.eoc = 1'b1;
                case (s_q.src)
                  adcsc_pkg::SRC_SEQ: s_d.pos = s_q.pos + 6'h01;
                  adcsc_pkg::SRC_EIM: begin
                    s_d.eim_left = s_q.eim_left - 8'h01;
                    s_d.irq_eim = s_q.eim_left == 8'h01;
                  end
                  adcsc_pkg::SRC_ESM: begin
                    s_d.esm_left[s_q.chan] = 1'b0;
                    s_d.irq_esm = (s_q.esm_left & ~(8'h01 << s_q.chan)) == 8'h00;
                  end
                  default: s_d.pos = s_q.pos;
                endcase
              end else begin
                nsar[s_q.bit_idx - 4'h1] = 1'b1;
                s_d.bit_idx = s_q.bit_idx - 4'h1;
              end
              s_d.sar = nsar;
            end else begin
              s_d.tick_cnt = s_q.tick_cnt + 3'h1;
            end
          end
        end
        default: s_d.st = adcsc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.sw_mode <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign mux_sel = s_q.chan;
  assign sample_hold = s_q.st == adcsc_pkg::ST_SAMPLE;
  assign dac_code = s_q.sar;
  assign power_up_bit = s_q.pwr_up;
  assign analog_power_level = s_q.plevel;
  assign ch_result = s_q.res;
  assign ch_valid = s_q.res_valid;
  assign dma_req = s_q.dma_req;
  assign irq_conv = s_q.irq_conv;
  assign irq_eim = s_q.irq_eim;
  assign irq_esm = s_q.irq_esm;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_SW_IGNORE: assert property (s_q.sw_mode && priority_event && s_q.eim_left == 8'h00 |=>
    s_q.eim_left == 8'h00) else $error("event taken in software mode");
  AST_SOC_BUSY: assert property (conv_start && s_d.src == adcsc_pkg::SRC_SW |=>
    (s_q.st != adcsc_pkg::ST_IDLE)[*3]) else $error("software conversion not busy");
  AST_EOC_SET: assert property (conv_done |=> s_q.eoc && s_q.dma_req && s_q.irq_conv)
    else $error("end flag or dma missing");
  AST_EOC_CLR: assert property (rd_go && s_axi_araddr == adcsc_pkg::OFF_CTRL && !conv_done
    |=> !s_q.eoc) else $error("end flag not cleared by read");
  AST_ABORT: assert property (eim_take && s_q.st != adcsc_pkg::ST_IDLE && s_q.src == adcsc_pkg::SRC_SEQ
    |=> s_q.st == adcsc_pkg::ST_IDLE ##1 s_q.src == adcsc_pkg::SRC_EIM) else $error("no abort");
  AST_PRIO: assert property (conv_start && s_q.eim_left != 8'h00 && !s_q.sw_mode
    |=> s_q.src == adcsc_pkg::SRC_EIM && s_q.chan == $past(s_q.prio_ch)) else $error("priority lost");
  AST_RESTART: assert property (s_q.st == adcsc_pkg::ST_IDLE && s_q.run && s_q.sw_mode
    |=> s_q.pos == 6'h00 && !s_q.sw_mode) else $error("no restart at first slot");
  AST_DEBUG: assert property (converter_debug_suspend && !s_q.sw_mode && s_q.st == adcsc_pkg::ST_IDLE
    |=> s_q.st == adcsc_pkg::ST_IDLE) else $error("sequencer ran in debug suspend");
  AST_SUSP: assert property (s_q.run && !s_q.sw_mode && !any_en && s_q.st == adcsc_pkg::ST_IDLE
    |=> s_q.st == adcsc_pkg::ST_IDLE) else $error("conversion in suspend");
  AST_ACTIVE_CHANNEL_NUMBER: assert property (conv_start |=> s_q.active_channel_number == s_q.chan && sample_hold)
    else $error("channel number not updated");
  AST_ESM_IRQ: assert property (s_q.irq_esm |-> $past(s_q.src) == adcsc_pkg::SRC_ESM
    && s_q.esm_left == 8'h00) else $error("bad exception interrupt");
endmodule
`default_nettype wire

// ==== tb_adc_sequencer_control.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_adc_sequencer_control;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic dbg = 1'h0, pev = 1'h0, eev = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, comp, sh, pup, dma, irqc, irqe, irqs;
  logic [1:0] bresp, rresp, apl, rr;
  logic [31:0] rdata, rv;
  logic [2:0] msel;
  logic [9:0] dac;
  logic [79:0] res;
  logic [7:0] chv;
  int error_cnt = 0, n_tests = 0, cyc = 0, nv = 0, nd = 0, ne = 0, ns = 0, nc = 0, t0, d0;

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge clk) begin
    if (chv !== 8'h00) nv++;
    if (dma === 1'h1) nd++;
    if (irqc === 1'h1) nc++;
    if (irqe === 1'h1) ne++;
    if (irqs === 1'h1) ns++;
  end

  adcsc_top u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .converter_debug_suspend(dbg),
    .priority_event(pev), .exception_event(eev), .comp_hi(comp), .mux_sel(msel), .sample_hold(sh),
    .dac_code(dac), .power_up_bit(pup), .analog_power_level(apl), .ch_result(res), .ch_valid(chv),
    .dma_req(dma), .irq_conv(irqc), .irq_eim(irqe), .irq_esm(irqs));

  adcsc_analog_model u_ana (.clk(clk), .mux_sel(msel), .sample_hold(sh), .dac_code(dac), .comp_hi(comp));

  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic fail();
    error_cnt++;
    wrap_up();
  endtask

  // handshakes are judged at the settled negedge and acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic ao, wo, bo;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      ao = awvalid & awready;
      wo = wvalid & wready;
      bo = bvalid;
      @(posedge clk);
      if (ao) awvalid <= 1'h0;
      if (wo) wvalid <= 1'h0;
      if (bo) begin
        bready <= 1'h0;
        break;
      end
    end
    if (i == 100) fail();
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    int i;
    logic ao, ro;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      ao = arvalid & arready;
      ro = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge clk);
      if (ao) arvalid <= 1'h0;
      if (ro) begin
        rready <= 1'h0;
        break;
      end
    end
    if (i == 100) fail();
    @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    rd(a);
    chk(rv & m, exp);
  endtask

  task automatic wait_ch(input logic [2:0] ch);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (chv !== 8'h00) break;
    end
    if (i == 3000) fail();
    chk({24'h00_0000, chv}, 32'h0000_0001 << ch);
    chk({22'h00_0000, res[ch*10 +: 10]}, {22'h00_0000, ch, 7'h2a});
    @(posedge clk);
  endtask

  task automatic ev(input logic p, input logic e);
    pev <= p;
    eev <= e;
    @(posedge clk);
    pev <= 1'h0;
    eev <= 1'h0;
    @(posedge clk);
  endtask

  task automatic quiet(input int n);
    int k;
    k = nv;
    repeat (n) @(posedge clk);
    chk(nv - k, 0);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rdc(adcsc_pkg::OFF_CTRL, 32'hffff_ffff, 32'h0000_0000);
    rdc(adcsc_pkg::OFF_GCTL, 32'hffff_ffff, 32'h0000_0000);
    rdc(adcsc_pkg::OFF_SEQFB, 32'hffff_ffff, 32'h0000_0100);
    rd(8'h40);
    chk({30'h0000_0000, rr}, {30'h0000_0000, adcsc_pkg::RESP_SLVERR});
    wr(adcsc_pkg::OFF_GSTAT, 32'hffff_ffff);
    rdc(adcsc_pkg::OFF_GSTAT, 32'hffff_ffff, 32'h0000_0000);
    wr(adcsc_pkg::OFF_GCTL, 32'h0000_0300);
    wr(adcsc_pkg::OFF_CTRL, 32'h0000_0001);
    chk({29'h0000_0000, pup, apl}, 32'h0000_0007);
    t0 = cyc;
    wr(adcsc_pkg::OFF_CTRL, 32'h0000_0055);
    rdc(adcsc_pkg::OFF_CTRL, 32'h0000_0004, 32'h0000_0004);
    rdc(adcsc_pkg::OFF_GSTAT, 32'h0000_0039, 32'h0000_0029);
    wait_ch(3'h5);
    d0 = cyc - t0;
    rdc(adcsc_pkg::OFF_CTRL, 32'h0000_000c, 32'h0000_0008);
    rdc(adcsc_pkg::OFF_CTRL, 32'h0000_0008, 32'h0000_0000);
    wr(adcsc_pkg::OFF_GCTL, 32'h0000_0302);
    dbg <= 1'h1;
    t0 = cyc;
    wr(adcsc_pkg::OFF_CTRL, 32'h0000_0015);
    wait_ch(3'h1);
    chk((cyc - t0 - d0 > 80) && (cyc - t0 - d0 < 96), 32'h0000_0001);
    dbg <= 1'h0;
    rd(adcsc_pkg::OFF_CTRL);
    wr(adcsc_pkg::OFF_GCTL, 32'h0000_0303);
    wr(adcsc_pkg::OFF_SEQLO, 32'h0000_0004);
    wr(adcsc_pkg::OFF_PRIO, 32'h0000_0106);
    wr(adcsc_pkg::OFF_EXC, 32'h0000_0003);
    wr(adcsc_pkg::OFF_SEQFB, 32'h0000_0001);
    wait_ch(3'h2);
    ev(1'h1, 1'h1);
    wait_ch(3'h6);
    wait_ch(3'h6);
    chk(ne, 1);
    wait_ch(3'h0);
    wait_ch(3'h1);
    chk(ns, 1);
    wait_ch(3'h2);
    ev(1'h0, 1'h1);
    wait_ch(3'h0);
    ev(1'h1, 1'h0);
    wait_ch(3'h6);
    wait_ch(3'h6);
    wait_ch(3'h1);
    wait_ch(3'h2);
    chk(ns, 2);
    wr(adcsc_pkg::OFF_SEQLO, 32'h0000_0000);
    wait_ch(3'h2);
    rdc(adcsc_pkg::OFF_SEQFB, 32'h0000_0200, 32'h0000_0200);
    wr(adcsc_pkg::OFF_CTRL, 32'h0000_0055);
    ev(1'h0, 1'h1);
    quiet(600);
    wr(adcsc_pkg::OFF_SEQLO, 32'h0000_0004);
    wait_ch(3'h2);
    dbg <= 1'h1;
    repeat (400) @(posedge clk);
    ev(1'h1, 1'h0);
    quiet(600);
    dbg <= 1'h0;
    wr(adcsc_pkg::OFF_SEQFB, 32'h0000_0000);
    wait_ch(3'h2);
    rdc(adcsc_pkg::OFF_SEQFB, 32'h0000_0101, 32'h0000_0100);
    ev(1'h1, 1'h1);
    quiet(600);
    wr(adcsc_pkg::OFF_SEQLO, 32'h0000_0804);
    wr(adcsc_pkg::OFF_SEQFB, 32'h0000_0001);
    wait_ch(3'h2);
    wait_ch(3'h3);
    chk(nd, nv);
    chk(nc, nv);
    wrap_up();
  end
endmodule
`default_nettype wire
